/* pkg/tmcr_pkg.sv */
// Purpose: constants of the temperature monitor register block
// Assumes: 25 MHz system clock
// Notes: register indices are the 3-bit serial command addresses
package tmcr_pkg;
    // ---------------------------------------------------------------
    // clock and timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int CONV_MS = 240;
    localparam int SPS_CONV_MS = 60;
    localparam int SPS_PERIOD_MS = 1000;
    localparam int CONV_CYC = CLK_HZ / 1000 * CONV_MS;
    localparam int SPS_CONV_CYC = CLK_HZ / 1000 * SPS_CONV_MS;
    localparam int SPS_PERIOD_CYC = CLK_HZ / 1000 * SPS_PERIOD_MS;
    localparam int SRST_ONES = 32;
    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [2:0] A_STATUS = 3'h0;
    localparam logic [2:0] A_CFG = 3'h1;
    localparam logic [2:0] A_RESULT = 3'h2;
    localparam logic [2:0] A_ID = 3'h3;
    localparam logic [2:0] A_CRIT = 3'h4;
    localparam logic [2:0] A_HYST = 3'h5;
    localparam logic [2:0] A_UPPER = 3'h6;
    localparam logic [2:0] A_LOWER = 3'h7;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam logic [15:0] CRIT_RST = 16'h4980;
    localparam logic [7:0] HYST_RST = 8'h05;
    localparam logic [15:0] UPPER_RST = 16'h2000;
    localparam logic [15:0] LOWER_RST = 16'h0500;
    // ---------------------------------------------------------------
    // configuration fields and modes
    // ---------------------------------------------------------------
    localparam int CFG_FQ_LSB = 0;
    localparam int CFG_CRIT_POL = 2;
    localparam int CFG_ALARM_POL = 3;
    localparam int CFG_CMP_MODE = 4;
    localparam int CFG_MODE_LSB = 5;
    localparam int CFG_RES16 = 7;
    localparam logic [1:0] MODE_CONT = 2'h0;
    localparam logic [1:0] MODE_ONESHOT = 2'h1;
    localparam logic [1:0] MODE_SPS = 2'h2;
    localparam logic [1:0] MODE_SHDN = 2'h3;
    localparam int HYST_SHIFT = 7;
    // event index: lower, upper, critical
    localparam int EV_LOW = 0;
    localparam int EV_HIGH = 1;
    localparam int EV_CRIT = 2;

    function automatic logic tmcr_is16(input logic [2:0] a);
        return (a == A_RESULT) || (a == A_CRIT) || (a == A_UPPER) || (a == A_LOWER);
    endfunction : tmcr_is16
endpackage : tmcr_pkg

/* rtl/tmcr_monitor.sv */
// Purpose: configuration, result, identity and limit logic
// Assumes: adc_code_i is a 16-bit code on clk_sys_i, valid at done
// Notes: alarm and critical pins are open drain, low when driven
//
// Overview of operation
// [RL1] fault queue bits 1:0 need 1 to 4 consecutive faults
// [RL2] config bit 2 sets critical pin active level, default low
// [RL3] config bit 3 sets alarm pin active level, default low
// [RL4] config bit 4: zero latches events, one follows comparison
// [RL5] mode 00 converts continuously, restarting at each completion
// [RL6] mode 01 runs one conversion of 240 ms
// [RL7] mode 10 converts 60 ms once per second
// [RL8] mode 11 stops conversions while register access still works
// [RL9] config bit 7 picks 13-bit or 16-bit resolution
// [RL10] result is a 16-bit twos complement word at address 2
// [RL11] in 13-bit mode low bits hold critical, upper, lower flags
// [RL12] in 16-bit mode low bits hold temperature, no flags
// [RL13] 13-bit bit 0 is one when below lower limit
// [RL14] 13-bit bit 1 is one when above upper limit
// [RL15] 13-bit bit 2 is one when above critical limit
// [RL16] bit 15 is sign; result resets to zero, read only
// [RL17] identity register at 3 holds maker and revision codes
// [RL18] critical pin activates when result exceeds critical limit
// [RL19] critical limit at 4 is read-write, resets to 0x4980
// [RL20] hysteresis lowers upper and critical, raises lower, to clear
// [RL21] a passing conversion restarts the fault count
// [RL22] writes to result and identity registers are ignored
`timescale 1ns/10ps
module tmcr_monitor import tmcr_pkg::*; #(
    parameter int CONV_CYCLES = CONV_CYC,
    parameter int SPS_CONV_CYCLES = SPS_CONV_CYC,
    parameter int SPS_PERIOD_CYCLES = SPS_PERIOD_CYC,
    // arbitrary identity values
    parameter logic [4:0] MAKER_ID = 5'h0a,
    parameter logic [2:0] REV_ID = 3'h1
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // serial pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    output logic dout_o,
    output logic dout_oe_o,
    // converter
    input wire logic [15:0] adc_code_i,
    output logic adc_power_o,
    output logic adc_done_o,
    // open-drain outputs
    output logic critical_pin_o,
    output logic critical_pin_oe_o,
    output logic alarm_pin_o,
    output logic alarm_pin_oe_o
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_WAIT = 2'b10
    } tmcr_state_t;

    tmcr_state_t state_q, state_d;
    logic [25:0] cnt_q, cnt_d;
    logic [7:0] cfg_q, hyst_q;
    logic [15:0] result_q, crit_q, upper_q, lower_q;
    logic [2:0] flag_q, evt_q, viol, clr;
    logic [1:0] fq_cnt_q [3];
    logic crit_oe_q, alarm_oe_q;
    logic [2:0] addr;
    logic [15:0] wr_data, rd_data;
    logic rd, wr, srst;

    // ---------------------------------------------------------------
    // serial port
    // ---------------------------------------------------------------
    tmcr_spi_slave u_spi (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .sclk_i(sclk_i),
        .cs_n_i(cs_n_i),
        .din_i(din_i),
        .dout_o(dout_o),
        .dout_oe_o(dout_oe_o),
        .addr_o(addr),
        .rd_data_i(rd_data),
        .rd_o(rd),
        .wr_o(wr),
        .wr_data_o(wr_data),
        .srst_o(srst)
    );

    // ---------------------------------------------------------------
    // register decode
    // ---------------------------------------------------------------
    wire [1:0] mode = cfg_q[CFG_MODE_LSB +: 2];
    wire [1:0] fq = cfg_q[CFG_FQ_LSB +: 2];
    wire res16 = cfg_q[CFG_RES16];
    wire cmp_mode = cfg_q[CFG_CMP_MODE];
    wire wr_cfg = wr & (addr == A_CFG);
    wire rd_result = rd & (addr == A_RESULT);
    wire mode_wr = wr_cfg & (wr_data[CFG_MODE_LSB +: 2] != MODE_SHDN);

    always_comb begin
        unique case (addr)
            A_CFG: rd_data = {8'h00, cfg_q};
            A_RESULT: rd_data = result_q; // RL10
            A_ID: rd_data = {8'h00, MAKER_ID, REV_ID}; // RL17
            A_CRIT: rd_data = crit_q;
            A_HYST: rd_data = {8'h00, hyst_q};
            A_UPPER: rd_data = upper_q;
            A_LOWER: rd_data = lower_q;
            A_STATUS: rd_data = 16'h0000;
        endcase
    end

    // only writable registers decode; result and identity never take writes
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_q <= CFG_RST;
            crit_q <= CRIT_RST; // RL19
            hyst_q <= HYST_RST;
            upper_q <= UPPER_RST;
            lower_q <= LOWER_RST;
        end else if (srst) begin
            cfg_q <= CFG_RST;
            crit_q <= CRIT_RST;
            hyst_q <= HYST_RST;
            upper_q <= UPPER_RST;
            lower_q <= LOWER_RST;
        end else if (wr) begin // RL22
            if (addr == A_CFG)
                cfg_q <= wr_data[7:0];
            if (addr == A_CRIT)
                crit_q <= wr_data; // RL19
            if (addr == A_HYST)
                hyst_q <= wr_data[7:0];
            if (addr == A_UPPER)
                upper_q <= wr_data;
            if (addr == A_LOWER)
                lower_q <= wr_data;
        end
    end

    // ---------------------------------------------------------------
    // conversion sequencer
    // ---------------------------------------------------------------
    wire [25:0] conv_len = (mode == MODE_SPS) ? 26'(SPS_CONV_CYCLES) // RL7
                                             : 26'(CONV_CYCLES); // RL6
    wire [25:0] wait_len = 26'(SPS_PERIOD_CYCLES - SPS_CONV_CYCLES);
    wire done = (state_q == ST_CONV) && (cnt_q == conv_len - 26'h1);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q + 26'h1;
        unique case (state_q)
            ST_IDLE: begin
                cnt_d = 26'h0;
                if (mode == MODE_CONT || mode == MODE_SPS)
                    state_d = ST_CONV;
            end
            ST_CONV: begin
                if (done) begin
                    cnt_d = 26'h0;
                    if (mode == MODE_CONT)
                        state_d = ST_CONV; // RL5
                    else if (mode == MODE_SPS)
                        state_d = ST_WAIT; // RL7
                    else
                        state_d = ST_IDLE; // RL6
                end
            end
            ST_WAIT: begin
                if (cnt_q == wait_len - 26'h1) begin
                    cnt_d = 26'h0;
                    state_d = ST_CONV;
                end
            end
            default: begin
                cnt_d = 26'h0;
                state_d = ST_IDLE;
            end
        endcase
        if (mode_wr) begin
            cnt_d = 26'h0;
            state_d = ST_CONV;
        end
        if (wr_cfg && wr_data[CFG_MODE_LSB +: 2] == MODE_SHDN)
            state_d = ST_IDLE; // RL8
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= ST_IDLE;
            cnt_q <= 26'h0;
        end else if (srst) begin
            state_q <= ST_IDLE;
            cnt_q <= 26'h0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    assign adc_power_o = (state_q != ST_IDLE); // RL8
    assign adc_done_o = done;

    // ---------------------------------------------------------------
    // limit comparison with hysteresis
    // ---------------------------------------------------------------
    wire [15:0] temp = res16 ? adc_code_i : {adc_code_i[15:3], 3'h0}; // RL9
    wire signed [16:0] t_s = signed'({temp[15], temp});
    wire signed [16:0] h_s = signed'(17'({hyst_q[3:0], 7'h00}));
    wire signed [16:0] low_s = signed'({lower_q[15], lower_q});
    wire signed [16:0] up_s = signed'({upper_q[15], upper_q});
    wire signed [16:0] crit_s = signed'({crit_q[15], crit_q});

    assign viol[EV_LOW] = t_s < low_s; // RL13
    assign viol[EV_HIGH] = t_s > up_s; // RL14
    assign viol[EV_CRIT] = t_s > crit_s; // RL15 RL18
    assign clr[EV_LOW] = t_s > low_s + h_s; // RL20
    assign clr[EV_HIGH] = t_s < up_s - h_s; // RL20
    assign clr[EV_CRIT] = t_s < crit_s - h_s; // RL20

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i)
            result_q <= RESULT_RST; // RL16
        else if (srst)
            result_q <= RESULT_RST;
        else if (done)
            result_q <= res16 ? adc_code_i : {adc_code_i[15:3], viol}; // RL11 RL12
    end

    // ---------------------------------------------------------------
    // fault queue and event latches, one per limit
    // ---------------------------------------------------------------
    for (genvar i = 0; i < 3; i++) begin : g_ev
        wire rise_ev = done & viol[i] & (fq_cnt_q[i] == fq) & ~flag_q[i];
        always_ff @(posedge clk_sys_i or negedge resetn_i) begin
            if (!resetn_i) begin
                fq_cnt_q[i] <= 2'h0;
                flag_q[i] <= 1'b0;
                evt_q[i] <= 1'b0;
            end else if (srst) begin
                fq_cnt_q[i] <= 2'h0;
                flag_q[i] <= 1'b0;
                evt_q[i] <= 1'b0;
            end else begin
                if (done && viol[i]) begin
                    if (fq_cnt_q[i] == fq)
                        flag_q[i] <= 1'b1; // RL1
                    else
                        fq_cnt_q[i] <= fq_cnt_q[i] + 2'h1; // RL1
                end else if (done) begin
                    fq_cnt_q[i] <= 2'h0; // RL21
                    if (clr[i])
                        flag_q[i] <= 1'b0; // RL20
                end
                // a new event beats a clearing read
                if (rise_ev)
                    evt_q[i] <= 1'b1; // RL4
                else if (rd_result)
                    evt_q[i] <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // output pins
    // ---------------------------------------------------------------
    wire crit_act = cmp_mode ? flag_q[EV_CRIT] : evt_q[EV_CRIT]; // RL4 RL18
    wire alarm_act = cmp_mode ? |flag_q[EV_HIGH:EV_LOW] : |evt_q[EV_HIGH:EV_LOW];

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            crit_oe_q <= 1'b0;
            alarm_oe_q <= 1'b0;
        end else begin
            crit_oe_q <= crit_act ^ cfg_q[CFG_CRIT_POL]; // RL2
            alarm_oe_q <= alarm_act ^ cfg_q[CFG_ALARM_POL]; // RL3
        end
    end

    assign critical_pin_o = 1'b0;
    assign critical_pin_oe_o = crit_oe_q;
    assign alarm_pin_o = 1'b0;
    assign alarm_pin_oe_o = alarm_oe_q;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    a_fault_queue_depth: assert property ($rose(flag_q[EV_CRIT]) |->
        $past(done) && $past(fq_cnt_q[EV_CRIT]) == $past(fq)) // RL1
        else $error("critical flag set before queue filled");
    a_crit_pin_level: assert property (critical_pin_oe_o ==
        ($past(crit_act) ^ $past(cfg_q[CFG_CRIT_POL]))) // RL2
        else $error("critical pin polarity wrong");
    a_alarm_pin_level: assert property (!cmp_mode && evt_q[EV_HIGH] ##1 !cmp_mode
        |-> alarm_pin_oe_o != $past(cfg_q[CFG_ALARM_POL])) // RL3
        else $error("alarm pin not active on latched event");
    a_cmp_follow: assert property (cmp_mode && flag_q[EV_CRIT] |=>
        critical_pin_oe_o != $past(cfg_q[CFG_CRIT_POL])) // RL4
        else $error("comparator mode does not follow flag");
    a_cont_restart: assert property (done && mode == MODE_CONT && !wr
        && !srst |=> state_q == ST_CONV && cnt_q == 26'h0) // RL5
        else $error("continuous mode did not restart");
    a_shutdown_idle: assert property (mode == MODE_SHDN |-> state_q == ST_IDLE
        && !adc_power_o) // RL8
        else $error("conversion running in shutdown");
    a_flag_bits: assert property (done && !res16 && !srst |=>
        result_q[2:0] == $past(viol)) // RL11
        else $error("result flags wrong");
    a_full_word: assert property (done && res16 && !srst |=>
        result_q == $past(adc_code_i)) // RL12
        else $error("16-bit result wrong");
    a_ro_result: assert property (wr && addr == A_RESULT && !done && !srst
        |=> $stable(result_q)) // RL22
        else $error("result register took a write");
    a_queue_restart: assert property (done && !viol[EV_HIGH] && !srst
        |=> fq_cnt_q[EV_HIGH] == 2'h0) // RL21
        else $error("fault count not restarted");

    c_oneshot: cover property (mode == MODE_ONESHOT && done);
    c_crit_event: cover property ($rose(flag_q[EV_CRIT]));
    c_serial_reset: cover property (srst);
endmodule : tmcr_monitor

/* rtl/tmcr_spi_slave.sv */
// Purpose: serial register port, sampled by the system clock
// Assumes: serial clock idles high, at most an eighth of clk_sys_i
// Notes: data in on rising, out on falling serial clock edges
`timescale 1ns/10ps
module tmcr_spi_slave import tmcr_pkg::*; (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // serial pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    output logic dout_o,
    output logic dout_oe_o,
    // register side
    output logic [2:0] addr_o,
    input wire logic [15:0] rd_data_i,
    output logic rd_o,
    output logic wr_o,
    output logic [15:0] wr_data_o,
    output logic srst_o
);
    logic [2:0] sclk_s_q, cs_s_q, din_s_q;
    logic [4:0] bcnt_q;
    logic [15:0] shin_q, shout_q;
    logic [5:0] ones_q;
    logic cmd_rd_q, cmd_ok_q, rd_pend_q;
    logic [2:0] addr_q;
    logic dout_q, oe_q, rd_q, wr_q, srst_q;
    logic [15:0] wdat_q;

    wire rise = sclk_s_q[1] & ~sclk_s_q[2];
    wire fall = ~sclk_s_q[1] & sclk_s_q[2];
    wire sel = ~cs_s_q[1];
    wire din = din_s_q[1];
    wire [7:0] cmd = {shin_q[6:0], din};
    wire cmd_end = sel & rise & (bcnt_q == 5'd7);
    wire [4:0] last = tmcr_is16(addr_q) ? 5'd23 : 5'd15;
    wire wr_end = sel & rise & (bcnt_q == last) & cmd_ok_q & ~cmd_rd_q;
    wire ones_full = rise & din & (ones_q == 6'(SRST_ONES - 1));

    // ---------------------------------------------------------------
    // pin synchronisers and framing
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sclk_s_q <= 3'h7;
            cs_s_q <= 3'h7;
            din_s_q <= 3'h0;
        end else begin
            sclk_s_q <= {sclk_s_q[1:0], sclk_i};
            cs_s_q <= {cs_s_q[1:0], cs_n_i};
            din_s_q <= {din_s_q[1:0], din_i};
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bcnt_q <= 5'h0;
            shin_q <= 16'h0;
            ones_q <= 6'h0;
            srst_q <= 1'b0;
        end else begin
            srst_q <= ones_full;
            if (rise)
                ones_q <= (din && !ones_full) ? ones_q + 6'h1 : 6'h0;
            if (!sel || srst_q)
                bcnt_q <= 5'h0;
            else if (rise) begin
                shin_q <= {shin_q[14:0], din};
                if (bcnt_q != 5'h1f)
                    bcnt_q <= bcnt_q + 5'h1;
            end
        end
    end

    // ---------------------------------------------------------------
    // command, read load and write strobe
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmd_rd_q <= 1'b0;
            cmd_ok_q <= 1'b0;
            addr_q <= 3'h0;
            rd_pend_q <= 1'b0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            wdat_q <= 16'h0;
        end else begin
            rd_pend_q <= 1'b0;
            rd_q <= rd_pend_q;
            wr_q <= wr_end & ~srst_q;
            if (!sel)
                cmd_ok_q <= 1'b0;
            if (cmd_end) begin
                cmd_rd_q <= cmd[6];
                addr_q <= cmd[5:3];
                cmd_ok_q <= (cmd[7] == 1'b0) && (cmd[2:0] == 3'h0);
                rd_pend_q <= (cmd[7] == 1'b0) && (cmd[2:0] == 3'h0) && cmd[6];
            end
            if (wr_end)
                wdat_q <= {shin_q[14:0], din};
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            shout_q <= 16'h0;
            dout_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            oe_q <= sel;
            if (rd_pend_q)
                shout_q <= tmcr_is16(addr_q) ? rd_data_i : {rd_data_i[7:0], 8'h00};
            else if (sel && fall && bcnt_q >= 5'd8 && cmd_rd_q) begin
                dout_q <= shout_q[15];
                shout_q <= {shout_q[14:0], 1'b0};
            end
        end
    end

    assign addr_o = addr_q;
    assign rd_o = rd_q;
    assign wr_o = wr_q;
    assign wr_data_o = wdat_q;
    assign srst_o = srst_q;
    assign dout_o = dout_q;
    assign dout_oe_o = oe_q;

    a_srst_ones: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        srst_o |-> $past(ones_q) == 6'(SRST_ONES - 1))
        else $error("interface reset without full run of ones");
endmodule : tmcr_spi_slave

/* tb/tmcr_host_model.sv */
// Purpose: host side of the serial register port
// Assumes: mode 3 link, serial clock idles high, 320 ns period
// Notes: din changes after falling edges, dout taken at rising edges
`timescale 1ns/10ps
module tmcr_host_model (
    // serial pins
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o,
    input wire logic dout_i
);
    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        din_o = 1'b1;
    end

    // ---------------------------------------------------------------
    // one frame: command byte, then n data bits msb first
    // ---------------------------------------------------------------
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, input int n,
                        output logic [15:0] rd);
        logic [23:0] w;
        w = {cmd, wd << (16 - n)};
        rd = 16'h0000;
        cs_n_o = 1'b0;
        #160;
        for (int i = 0; i < 8 + n; i++) begin
            sclk_o = 1'b0;
            din_o = w[23 - i];
            #160;
            sclk_o = 1'b1;
            if (i >= 8) begin
                rd = {rd[14:0], dout_i};
            end
            #160;
        end
        // din flips so a stale level is never mistaken for data
        din_o = ~din_o;
        cs_n_o = 1'b1;
        #400;
    endtask : xfer
endmodule : tmcr_host_model

/* tb/tmcr_monitor_tb_top.sv */
// Purpose: register and limit checks of the temperature monitor
// Assumes: shortened conversion counts
// Notes: converter codes are driven straight by the bench
`timescale 1ns/10ps
module tmcr_monitor_tb_top import tmcr_pkg::*;;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic sclk, cs_n, din, dout, dout_oe, adc_power, adc_done;
    logic crit_od, crit_oe, alarm_od, alarm_oe;
    logic [15:0] adc_code = 16'h0800;
    int errors = 0;
    int total_checks = 0;
    int n;
    logic [15:0] junk;

    always #20 clk_sys_i = ~clk_sys_i;

    tmcr_host_model HOST (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout));

    // identity values are arbitrary
    tmcr_monitor #(.CONV_CYCLES(40), .SPS_CONV_CYCLES(20), .SPS_PERIOD_CYCLES(100),
        .MAKER_ID(5'h15), .REV_ID(3'h2)) DUT (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .din_i(din), .dout_o(dout), .dout_oe_o(dout_oe), .adc_code_i(adc_code),
        .adc_power_o(adc_power), .adc_done_o(adc_done), .critical_pin_o(crit_od),
        .critical_pin_oe_o(crit_oe), .alarm_pin_o(alarm_od), .alarm_pin_oe_o(alarm_oe));

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic close_out();
        if (errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic rd(input logic [2:0] a, input int w, input logic [15:0] exp);
        logic [15:0] v;
        @(posedge clk_sys_i);
        #2;
        HOST.xfer({2'b01, a, 3'b000}, 16'h0000, w, v);
        chk("register read", exp, v);
    endtask : rd

    task automatic wr(input logic [2:0] a, input int w, input logic [15:0] d);
        logic [15:0] v;
        @(posedge clk_sys_i);
        #2;
        HOST.xfer({2'b00, a, 3'b000}, d, w, v);
    endtask : wr

    // count cycles up to the next completed conversion, then let the pins settle
    task automatic wait_done(output int k);
        k = 0;
        do begin
            @(posedge clk_sys_i);
            #2;
            k++;
        end while (adc_done !== 1'b1 && k < 2000);
        if (k >= 2000) begin
            errors++;
            close_out();
        end
        repeat (3) @(posedge clk_sys_i);
        #2;
    endtask : wait_done

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk_sys_i);
        #2;
        resetn_i = 1'b1;
        rd(A_CFG, 8, 16'h0000);
        rd(A_CRIT, 16, 16'h4980);
        rd(A_ID, 8, 16'h00aa);
        chk("critical oe", 16'h0, {15'h0, crit_oe});
        chk("alarm oe", 16'h0, {15'h0, alarm_oe});
        chk("open drain data", 16'h0, {14'h0, crit_od, alarm_od});
        chk("data out enable", 16'h0, {15'h0, dout_oe});
        wr(A_CRIT, 16, 16'h1000);
        rd(A_CRIT, 16, 16'h1000);
        wr(A_RESULT, 16, 16'hffff);
        wr(A_ID, 8, 16'h00ff);
        wait_done(n);
        rd(A_RESULT, 16, 16'h0800);
        rd(A_ID, 8, 16'h00aa);
        adc_code = 16'h2abc;
        wait_done(n);
        chk("critical oe", 16'h1, {15'h0, crit_oe});
        chk("alarm oe", 16'h1, {15'h0, alarm_oe});
        rd(A_RESULT, 16, 16'h2abe);
        adc_code = 16'h0100;
        wait_done(n);
        rd(A_RESULT, 16, 16'h0101);
        adc_code = 16'h2abc;
        wr(A_CFG, 8, 16'h001c);
        wait_done(n);
        chk("critical oe", 16'h0, {15'h0, crit_oe});
        chk("alarm oe", 16'h0, {15'h0, alarm_oe});
        adc_code = 16'h0800;
        wr(A_CFG, 8, 16'h0013);
        wait_done(n);
        chk("critical oe", 16'h0, {15'h0, crit_oe});
        adc_code = 16'h2abc;
        repeat (3) wait_done(n);
        chk("critical oe", 16'h0, {15'h0, crit_oe});
        wait_done(n);
        chk("critical oe", 16'h1, {15'h0, crit_oe});
        wr(A_CFG, 8, 16'h0080);
        wait_done(n);
        chk("converter power", 16'h1, {15'h0, adc_power});
        rd(A_RESULT, 16, 16'h2abc);
        wr(A_CFG, 8, 16'h0020);
        wait_done(n);
        chk("converter power", 16'h0, {15'h0, adc_power});
        wr(A_CFG, 8, 16'h0040);
        wait_done(n);
        wait_done(n);
        chk("sample spacing", 16'h1, {15'h0, n >= 95 && n <= 105});
        wr(A_CFG, 8, 16'h0060);
        n = 0;
        repeat (200) begin
            @(posedge clk_sys_i);
            #2;
            n += int'(adc_done === 1'b1);
        end
        chk("shutdown conversions", 16'h0, 16'(n));
        chk("converter power", 16'h0, {15'h0, adc_power});
        rd(A_CFG, 8, 16'h0060);
        // 48 ones across two frames trip the serial interface reset
        repeat (2) HOST.xfer(8'hff, 16'hffff, 16, junk);
        rd(A_CRIT, 16, 16'h4980);
        rd(A_CFG, 8, 16'h0000);
        close_out();
    end
endmodule : tmcr_monitor_tb_top
